// ---- verilog/flash_burst_pkg.sv ----
// Shared constants and types for the flash burst read port.
package flash_burst_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int CNT_W = 5;
  localparam int BASE_W = ADDR_W - CNT_W;
  localparam logic [CNT_W-1:0] CNT_START = 5'h00;
  localparam logic [CNT_W-1:0] CNT_LAST = 5'h1f;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam int FIFO_DEPTH = 8;

  // Timing figures in their own units, then cycle counts at 40 MHz.
  localparam int CLK_PERIOD_PS = 25000;
  localparam int ACC_NS = 70;
  localparam int SLEEP_MARGIN_NS = 30;
  localparam int RH_NS = 0;
  localparam int READY_NS = 20000;
  localparam int SLEEP_CYC_RAW = ((ACC_NS + SLEEP_MARGIN_NS) * 1000 + CLK_PERIOD_PS - 1)
                                 / CLK_PERIOD_PS;
  localparam int SLEEP_CYC = (SLEEP_CYC_RAW < 1) ? 1 : SLEEP_CYC_RAW;
  localparam int RH_CYC_RAW = (RH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RH_CYC = (RH_CYC_RAW < 1) ? 1 : RH_CYC_RAW;
  localparam int READY_CYC_RAW = (READY_NS * 1000) / CLK_PERIOD_PS;
  localparam int READY_CYC = (READY_CYC_RAW < 1) ? 1 : READY_CYC_RAW;
  localparam int TMR_W = 12;

  // Write cycles that make up one word program.
  localparam logic [2:0] PROG_WR_NORMAL = 3'h4;
  localparam logic [2:0] PROG_WR_BYPASS = 3'h2;
  localparam logic [2:0] PROG_WR_ZERO = 3'h0;

  // Control pins as one group; the idle value is the deselected bus.
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic lba_n;
    logic baa_n;
    logic bclk;
    logic rst_n;
  } pins_s;
  localparam int PIN_W = 7;
  localparam pins_s PINS_IDLE = 7'h7d;
  localparam int SYNC_W = PIN_W + ADDR_W + DATA_W;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {PINS_IDLE, 36'h0_0000_0000};

  // One burst word with its position in the burst.
  typedef struct packed {
    logic [CNT_W-1:0] idx;
    logic [DATA_W-1:0] data;
  } bword_s;
  localparam int BWORD_W = CNT_W + DATA_W;

  // One captured bus write cycle.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } wcycle_s;

  typedef enum logic [1:0] {
    MODE_ASYNC = 2'b01,
    MODE_BURST = 2'b10
  } mode_e;

  typedef enum logic [2:0] {
    RST_RUN = 3'b001,
    RST_HOLD = 3'b010,
    RST_RECOVER = 3'b100
  } rst_state_e;
endpackage

// ---- verilog/burst_fifo.sv ----
// Word FIFO between array prefetch and the burst output stage.
`timescale 1ns/100ps
module burst_fifo
  import flash_burst_pkg::*;
#(
  parameter int WIDTH = BWORD_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic flush_in,
  // Filling side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Draining side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PTR_W:0] wr_ptr_r;
  logic [PTR_W:0] rd_ptr_r;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign full = (wr_ptr_r[PTR_W] != rd_ptr_r[PTR_W]) &&
                (wr_ptr_r[PTR_W-1:0] == rd_ptr_r[PTR_W-1:0]);
  assign empty = (wr_ptr_r == rd_ptr_r);
  assign in_ready_out = !full && !flush_in;
  assign out_valid_out = !empty && !flush_in;
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem_r[rd_ptr_r[PTR_W-1:0]];

  always_ff @(posedge ref_clk_in)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r[PTR_W-1:0]] <= in_data_in;
    end
  end

  // Flush drops every stored word at once so a new burst never sees stale data.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in || flush_in)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule

// ---- verilog/flash_burst_read_port.sv ----
// Bus-side read, burst and reset control of the flash device.
`timescale 1ns/100ps
module flash_burst_read_port
  import flash_burst_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Flash bus control pins
  input wire logic chip_sel_n_in,
  input wire logic out_gate_n_in,
  input wire logic write_n_in,
  input wire logic hw_reset_n_in,
  input wire logic bus_clk_in,
  input wire logic load_start_addr_n_in,
  input wire logic advance_addr_n_in,
  // Flash bus address and data
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_out,
  // Flash bus status pins
  output logic last_word_flag_n_out,
  output logic op_done_flag_out,
  // Array read port
  output logic arr_rd_req_out,
  output logic [ADDR_W-1:0] arr_addr_out,
  input wire logic arr_rd_ack_in,
  input wire logic [DATA_W-1:0] arr_data_in,
  // Command decoder side
  output logic wr_cycle_valid_out,
  output wcycle_s wr_cycle_out,
  input wire logic cmd_burst_en_in,
  input wire logic cmd_burst_dis_in,
  input wire logic cmd_soft_reset_in,
  input wire logic cmd_bypass_enter_in,
  input wire logic cmd_bypass_exit_in,
  input wire logic cmd_seq_clear_in,
  output logic prog_seq_done_out,
  // Embedded algorithm side
  input wire logic algo_busy_in,
  output logic algo_abort_out,
  // Status
  output logic burst_mode_out,
  output logic bypass_mode_out,
  output logic sleep_out,
  output logic standby_out
);
  // Pin synchroniser: three stages, a change counts once stages two and three agree.
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [SYNC_W-1:0] sync3_r;
  logic [SYNC_W-1:0] filt_r;
  pins_s pin;
  pins_s pin_prev_r;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_data;

  assign raw = {chip_sel_n_in, out_gate_n_in, write_n_in, load_start_addr_n_in,
                advance_addr_n_in, bus_clk_in, hw_reset_n_in, addr_in, dq_in};

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      sync1_r <= SYNC_IDLE;
      sync2_r <= SYNC_IDLE;
      sync3_r <= SYNC_IDLE;
    end
    else
    begin
      sync1_r <= raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_filt
      always_ff @(posedge ref_clk_in)
      begin
        if (rst_in)
        begin
          filt_r[gi] <= SYNC_IDLE[gi];
        end
        else if (sync2_r[gi] == sync3_r[gi])
        begin
          filt_r[gi] <= sync3_r[gi];
        end
      end
    end
  endgenerate

  assign pin = filt_r[SYNC_W-1 -: PIN_W];
  assign bus_addr = filt_r[DATA_W +: ADDR_W];
  assign bus_data = filt_r[DATA_W-1:0];

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      pin_prev_r <= PINS_IDLE;
    end
    else
    begin
      pin_prev_r <= pin;
    end
  end

  // Edge events seen on the filtered pins.
  logic bclk_rise;
  logic ce_rise;
  logic we_rise;
  assign bclk_rise = pin.bclk && !pin_prev_r.bclk;
  assign ce_rise = pin.ce_n && !pin_prev_r.ce_n;
  assign we_rise = pin.we_n && !pin_prev_r.we_n;

  // Hardware reset pin handling and recovery.
  rst_state_e rst_state_r;
  logic [TMR_W-1:0] rh_cnt_r;
  logic [TMR_W-1:0] ready_cnt_r;
  logic active;
  logic rst_enter;
  assign active = (rst_state_r == RST_RUN);
  assign rst_enter = !pin.rst_n && (rst_state_r != RST_HOLD);

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      rst_state_r <= RST_RUN;
      rh_cnt_r <= '0;
    end
    else
    begin
      case (rst_state_r)
        RST_RUN:
        begin
          if (!pin.rst_n)
          begin
            rst_state_r <= RST_HOLD;
          end
        end
        RST_HOLD:
        begin
          if (pin.rst_n)
          begin
            rst_state_r <= RST_RECOVER;
            rh_cnt_r <= TMR_W'(RH_CYC);
          end
        end
        RST_RECOVER:
        begin
          if (!pin.rst_n)
          begin
            rst_state_r <= RST_HOLD;
          end
          else if (rh_cnt_r > TMR_W'(1))
          begin
            rh_cnt_r <= rh_cnt_r - 1'b1;
          end
          else
          begin
            rst_state_r <= RST_RUN;
          end
        end
        default:
        begin
          rst_state_r <= RST_RUN;
        end
      endcase
    end
  end

  // A reset that lands on a running algorithm keeps the flag busy for the internal reset time.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      ready_cnt_r <= '0;
      op_done_flag_out <= 1'b1;
      algo_abort_out <= 1'b0;
    end
    else
    begin
      algo_abort_out <= rst_enter;
      if (rst_enter && algo_busy_in)
      begin
        ready_cnt_r <= TMR_W'(READY_CYC);
      end
      else if (ready_cnt_r != '0)
      begin
        ready_cnt_r <= ready_cnt_r - 1'b1;
      end
      op_done_flag_out <= !algo_busy_in && (ready_cnt_r == '0) && !rst_enter;
    end
  end

  // Mode flags; the software reset command deliberately has no path into them.
  mode_e mode_r;
  logic bypass_r;
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in || !active)
    begin
      mode_r <= MODE_ASYNC;
      bypass_r <= 1'b0;
    end
    else
    begin
      if (cmd_burst_dis_in)
      begin
        mode_r <= MODE_ASYNC;
      end
      else if (cmd_burst_en_in)
      begin
        mode_r <= MODE_BURST;
      end
      if (cmd_bypass_exit_in)
      begin
        bypass_r <= 1'b0;
      end
      else if (cmd_bypass_enter_in)
      begin
        bypass_r <= 1'b1;
      end
    end
  end
  assign burst_mode_out = (mode_r == MODE_BURST);
  assign bypass_mode_out = bypass_r;

  // Burst engine: load, prefetch into the FIFO, output stage.
  logic burst_en;
  logic load_take;
  logic burst_live_r;
  logic [BASE_W-1:0] base_r;
  logic [CNT_W-1:0] start_lo_r;
  logic [CNT_W-1:0] fetch_k_r;
  logic [CNT_W-1:0] out_cnt_r;
  bword_s word_r;
  logic word_valid_r;
  logic adv_owed_r;
  logic flush;
  logic fetch_req;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  bword_s fifo_out;
  bword_s fifo_in;
  logic adv_edge;

  assign burst_en = active && burst_mode_out && !pin.ce_n;
  assign load_take = burst_en && bclk_rise && !pin.lba_n;
  assign adv_edge = burst_en && bclk_rise && pin.lba_n && !pin.baa_n;
  assign flush = load_take || ce_rise || !active || !burst_mode_out;
  assign fetch_req = burst_live_r && fifo_in_ready;
  assign fifo_in.idx = fetch_k_r;
  assign fifo_in.data = arr_data_in;
  assign fifo_pop = fifo_out_valid && burst_live_r && (!word_valid_r || adv_edge || adv_owed_r);

  burst_fifo #(
    .WIDTH(BWORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .flush_in(flush),
    .in_valid_in(fetch_req && arr_rd_ack_in),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fifo_in),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_out)
  );

  // Prefetch keeps walking modulo 32, so the array is read over again on each wrap.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      burst_live_r <= 1'b0;
      base_r <= '0;
      start_lo_r <= CNT_START;
      fetch_k_r <= CNT_START;
    end
    else if (load_take)
    begin
      burst_live_r <= 1'b1;
      base_r <= bus_addr[ADDR_W-1:CNT_W];
      start_lo_r <= bus_addr[CNT_W-1:0];
      fetch_k_r <= CNT_START;
    end
    else if (flush)
    begin
      burst_live_r <= 1'b0;
    end
    else if (fetch_req && arr_rd_ack_in)
    begin
      fetch_k_r <= fetch_k_r + CNT_ONE;
    end
  end

  // An advance that finds the FIFO empty is owed and served when the word arrives.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in || flush)
    begin
      word_valid_r <= 1'b0;
      word_r <= '0;
      out_cnt_r <= CNT_START;
      adv_owed_r <= 1'b0;
    end
    else
    begin
      if (fifo_pop)
      begin
        word_r <= fifo_out;
        word_valid_r <= 1'b1;
      end
      if (word_valid_r && (adv_edge || adv_owed_r) && fifo_pop)
      begin
        out_cnt_r <= out_cnt_r + CNT_ONE;
        adv_owed_r <= 1'b0;
      end
      else if (word_valid_r && adv_edge)
      begin
        adv_owed_r <= 1'b1;
      end
    end
  end
  assign last_word_flag_n_out = !(word_valid_r && burst_live_r && (out_cnt_r == CNT_LAST));

  // Asynchronous array reads and automatic sleep.
  logic [ADDR_W-1:0] async_addr_r;
  logic [DATA_W-1:0] async_data_r;
  logic async_valid_r;
  logic async_req_r;
  logic [TMR_W-1:0] stable_cnt_r;
  logic addr_moved;
  logic [ADDR_W-1:0] sleep_addr_r;
  logic addr_step;
  assign addr_moved = (bus_addr != async_addr_r);
  // Sleep watches the pins themselves, since burst mode parks the read address register.
  assign addr_step = (bus_addr != sleep_addr_r);

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in || !active || burst_mode_out)
    begin
      async_addr_r <= '0;
      async_valid_r <= 1'b0;
      async_req_r <= 1'b0;
    end
    else if (!pin.ce_n && (addr_moved || (!async_valid_r && !async_req_r)))
    begin
      async_addr_r <= bus_addr;
      async_valid_r <= 1'b0;
      async_req_r <= 1'b1;
    end
    else if (async_req_r && arr_rd_ack_in)
    begin
      async_req_r <= 1'b0;
      async_valid_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      async_data_r <= '0;
    end
    else if (async_req_r && arr_rd_ack_in && !burst_mode_out)
    begin
      async_data_r <= arr_data_in;
    end
  end

  // Sleep only gates power; the latched word keeps feeding the outputs.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      sleep_addr_r <= '0;
    end
    else
    begin
      sleep_addr_r <= bus_addr;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in || !active || addr_step)
    begin
      stable_cnt_r <= '0;
      sleep_out <= 1'b0;
    end
    else if (stable_cnt_r < TMR_W'(SLEEP_CYC))
    begin
      stable_cnt_r <= stable_cnt_r + 1'b1;
    end
    else
    begin
      sleep_out <= 1'b1;
    end
  end

  assign arr_rd_req_out = burst_mode_out ? fetch_req : async_req_r;
  assign arr_addr_out = burst_mode_out ? {base_r, CNT_W'(start_lo_r + fetch_k_r)}
                                       : async_addr_r;

  // Data pin drive.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      dq_out <= '0;
      dq_oe_out <= 1'b0;
      standby_out <= 1'b0;
    end
    else
    begin
      standby_out <= pin.ce_n && pin.rst_n;
      if (!active || pin.ce_n)
      begin
        dq_oe_out <= 1'b0;
      end
      else if (burst_mode_out)
      begin
        dq_oe_out <= !pin.oe_n && word_valid_r && burst_live_r;
        dq_out <= word_r.data;
      end
      else
      begin
        dq_oe_out <= !pin.oe_n && pin.we_n && async_valid_r;
        dq_out <= async_data_r;
      end
    end
  end

  // Command write capture and program cycle counting.
  logic [2:0] prog_cnt_r;
  logic [2:0] prog_need;
  logic wr_take;
  assign prog_need = bypass_r ? PROG_WR_BYPASS : PROG_WR_NORMAL;
  assign wr_take = active && we_rise && !pin.ce_n && pin.oe_n;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in || !active)
    begin
      wr_cycle_valid_out <= 1'b0;
      wr_cycle_out <= '0;
      prog_cnt_r <= PROG_WR_ZERO;
      prog_seq_done_out <= 1'b0;
    end
    else
    begin
      wr_cycle_valid_out <= wr_take;
      prog_seq_done_out <= 1'b0;
      if (wr_take)
      begin
        wr_cycle_out.addr <= bus_addr;
        wr_cycle_out.data <= bus_data;
      end
      if (cmd_seq_clear_in || cmd_soft_reset_in)
      begin
        prog_cnt_r <= PROG_WR_ZERO;
      end
      else if (wr_take && (prog_cnt_r + 3'h1 == prog_need))
      begin
        prog_cnt_r <= PROG_WR_ZERO;
        prog_seq_done_out <= 1'b1;
      end
      else if (wr_take)
      begin
        prog_cnt_r <= prog_cnt_r + 3'h1;
      end
    end
  end
endmodule

// ---- test/flash_burst_read_port_monitor.sv ----
// Checker for the flash burst read port, bound to its ports.
`timescale 1ns/100ps
module flash_burst_read_port_monitor
  import flash_burst_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Pins and commands
  input wire logic chip_sel_n_in,
  input wire logic out_gate_n_in,
  input wire logic hw_reset_n_in,
  input wire logic cmd_burst_en_in,
  input wire logic cmd_burst_dis_in,
  input wire logic cmd_soft_reset_in,
  input wire logic algo_busy_in,
  // Outputs
  input wire logic dq_oe_out,
  input wire logic last_word_flag_n_out,
  input wire logic op_done_flag_out,
  input wire logic burst_mode_out,
  input wire logic bypass_mode_out,
  input wire logic standby_out,
  input wire logic algo_abort_out
);
  logic [3:0] hi_cnt_r;
  logic [TMR_W-1:0] tmr_r;
  logic ent_r;
  logic pin_ok;
  default clocking mon_cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  // The reset pin passes a synchroniser, so it counts as settled only after ten high cycles.
  assign pin_ok = hi_cnt_r > 4'h9;
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in || !hw_reset_n_in)
      hi_cnt_r <= 4'h0;
    else if (hi_cnt_r != 4'hf)
      hi_cnt_r <= hi_cnt_r + 4'h1;
  end
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      tmr_r <= '1;
    else if ($fell(hw_reset_n_in))
      tmr_r <= '0;
    else if (tmr_r != '1)
      tmr_r <= tmr_r + 1'b1;
  end
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      ent_r <= 1'b0;
    else if ($fell(hw_reset_n_in))
      ent_r <= algo_busy_in;
  end
  sequence pin_drop;
    $fell(hw_reset_n_in) ##1 !hw_reset_n_in;
  endsequence
  sequence pin_held;
    !hw_reset_n_in [*7];
  endsequence
  chk_reset_quiet: assert property ($fell(rst_in) |->
    !dq_oe_out && op_done_flag_out && !burst_mode_out) else $error("outputs wrong after reset");
  chk_burst_entry: assert property (cmd_burst_en_in && pin_ok && op_done_flag_out
    |-> ##[1:3] burst_mode_out) else $error("burst mode not entered");
  chk_disable_exit: assert property (cmd_burst_dis_in |-> ##[1:3] !burst_mode_out)
    else $error("burst mode kept after disable");
  chk_soft_keep: assert property (burst_mode_out && cmd_soft_reset_in && pin_ok
    |=> burst_mode_out) else $error("soft reset left burst mode");
  chk_pin_reset: assert property (pin_held |->
    !burst_mode_out && !bypass_mode_out && !dq_oe_out) else $error("reset pin not obeyed");
  chk_abort_pulse: assert property (pin_drop |-> ##[1:6] algo_abort_out)
    else $error("no abort on reset pin");
  chk_standby_float: assert property ((chip_sel_n_in && pin_ok) [*7] |->
    standby_out && !dq_oe_out) else $error("standby not floating");
  chk_gate_float: assert property (out_gate_n_in [*7] |-> !dq_oe_out)
    else $error("driving with gate high");
  chk_busy_hold: assert property (ent_r && tmr_r > 8 && tmr_r < READY_CYC
    |-> !op_done_flag_out) else $error("busy released early");
  chk_busy_end: assert property (ent_r && tmr_r == READY_CYC + 10 |-> op_done_flag_out)
    else $error("busy held too long");
  chk_last_burst: assert property (!last_word_flag_n_out |-> burst_mode_out)
    else $error("last flag outside burst");
endmodule
bind flash_burst_read_port flash_burst_read_port_monitor flash_burst_read_port_monitor_inst (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .chip_sel_n_in(chip_sel_n_in),
  .out_gate_n_in(out_gate_n_in), .hw_reset_n_in(hw_reset_n_in),
  .cmd_burst_en_in(cmd_burst_en_in), .cmd_burst_dis_in(cmd_burst_dis_in),
  .cmd_soft_reset_in(cmd_soft_reset_in), .algo_busy_in(algo_busy_in), .dq_oe_out(dq_oe_out),
  .last_word_flag_n_out(last_word_flag_n_out), .op_done_flag_out(op_done_flag_out),
  .burst_mode_out(burst_mode_out), .bypass_mode_out(bypass_mode_out),
  .standby_out(standby_out), .algo_abort_out(algo_abort_out));

// ---- test/array_model.sv ----
// Behavioural flash array answering the read port's requests.
`timescale 1ns/100ps
module array_model
  import flash_burst_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic slow_in,
  input wire logic req_in,
  input wire logic [ADDR_W-1:0] addr_in,
  output logic ack_out,
  output logic [DATA_W-1:0] data_out
);
  logic [1:0] wait_r;
  // Between answers the data toggles each cycle, so a stale word read an odd number of cycles late reads inverted.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      ack_out <= 1'b0;
      wait_r <= 2'h0;
      data_out <= 16'h0000;
    end
    else if (req_in && !ack_out && (!slow_in || wait_r == 2'h3))
    begin
      ack_out <= 1'b1;
      wait_r <= 2'h0;
      data_out <= addr_in[15:0] ^ 16'h5a3c;
    end
    else
    begin
      ack_out <= 1'b0;
      data_out <= ~data_out;
      if (req_in && !ack_out)
        wait_r <= wait_r + 2'h1;
    end
  end
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the flash burst read port.
`timescale 1ns/100ps
module tb_top
  import flash_burst_pkg::*;
;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cs_n = 1'b1, gate_n = 1'b1, we_n = 1'b1, hrst_n = 1'b1, bclk = 1'b0;
  logic ld_n = 1'b1, adv_n = 1'b1, busy = 1'b0, slow = 1'b0;
  logic [5:0] cmds = 6'h00;
  logic [ADDR_W-1:0] addr = 20'h00000, arr_addr, cur;
  logic [DATA_W-1:0] dq_in = 16'h0000, dq_out, arr_data;
  logic dq_oe, last_n, done, req, ack, wr_v, seq_done, abort, bmode, bypass, sleep, stby;
  wcycle_s wr_c;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_seq = 0;
  int k;
  logic [31:0] r = 32'h9fb53387;
  logic [4:0] bcnt = 5'h00;
  always #12.5 ref_clk_in = ~ref_clk_in;
  flash_burst_read_port flash_burst_read_port_inst (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .chip_sel_n_in(cs_n), .out_gate_n_in(gate_n),
    .write_n_in(we_n), .hw_reset_n_in(hrst_n), .bus_clk_in(bclk), .load_start_addr_n_in(ld_n),
    .advance_addr_n_in(adv_n), .addr_in(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_out(dq_oe),
    .last_word_flag_n_out(last_n), .op_done_flag_out(done), .arr_rd_req_out(req),
    .arr_addr_out(arr_addr), .arr_rd_ack_in(ack), .arr_data_in(arr_data),
    .wr_cycle_valid_out(wr_v), .wr_cycle_out(wr_c), .cmd_burst_en_in(cmds[0]),
    .cmd_burst_dis_in(cmds[1]), .cmd_soft_reset_in(cmds[2]), .cmd_bypass_enter_in(cmds[3]),
    .cmd_bypass_exit_in(cmds[4]), .cmd_seq_clear_in(cmds[5]), .prog_seq_done_out(seq_done),
    .algo_busy_in(busy), .algo_abort_out(abort), .burst_mode_out(bmode),
    .bypass_mode_out(bypass), .sleep_out(sleep), .standby_out(stby));
  array_model array_model_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .slow_in(slow),
    .req_in(req), .addr_in(arr_addr), .ack_out(ack), .data_out(arr_data));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [15:0] word(input logic [19:0] a);
    return a[15:0] ^ 16'h5a3c;
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (seq_done === 1'b1)
      n_seq++;
    if (cyc == 20000)
    begin
      errors++;
      end_of_test();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_in);
    #2;
  endtask
  task automatic chk(input string nm, input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cmd(input int b);
    cmds = 6'h01 << b;
    step(1);
    cmds = 6'h00;
    step(1);
  endtask
  // One bus clock period; the pins change one cycle before the rise and pass the synchroniser one cycle ahead of it.
  task automatic bc(input logic l, input logic a, input logic g);
    ld_n = l;
    adv_n = a;
    gate_n = g;
    step(1);
    bclk = 1'b1;
    step(5);
    bclk = 1'b0;
    step(5);
  endtask
  task automatic see();
    chk("word", {dq_oe, last_n, dq_out}, {1'b1, bcnt != 5'h1f, word(cur)});
  endtask
  task automatic run(input logic [19:0] a, input int n);
    cur = a;
    addr = a;
    bcnt = 5'h00;
    bc(1'b0, 1'b1, 1'b0);
    step(20);
    see();
    repeat (n)
    begin
      bc(1'b1, 1'b0, 1'b0);
      cur[4:0] = cur[4:0] + 5'h01;
      bcnt = bcnt + 5'h01;
      see();
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    addr = a;
    dq_in = d;
    we_n = 1'b0;
    step(6);
    we_n = 1'b1;
    for (k = 0; k < 12 && wr_v !== 1'b1; k++)
      step(1);
    chk("write", {wr_v, wr_c}, {1'b1, a, d});
    step(2);
  endtask
  initial
  begin
    step(5);
    rst_in = 1'b0;
    cs_n = 1'b0;
    step(10);
    chk("idle", {dq_oe, done, bmode, last_n}, 4'b0101);
    cmd(0);
    step(4);
    chk("mode", bmode, 1'b1);
    run(20'h0001e, 34);
    $display("wrap test done");
    bc(1'b1, 1'b1, 1'b1);
    chk("suspend", dq_oe, 1'b0);
    bc(1'b1, 1'b1, 1'b0);
    see();
    bc(1'b1, 1'b1, 1'b0);
    see();
    bc(1'b1, 1'b0, 1'b0);
    cur[4:0] = cur[4:0] + 5'h01;
    bcnt = bcnt + 5'h01;
    see();
    $display("suspend test done");
    cs_n = 1'b1;
    step(10);
    chk("deselect", {dq_oe, stby, bmode}, 3'b011);
    cs_n = 1'b0;
    step(6);
    cmd(2);
    step(4);
    chk("soft", bmode, 1'b1);
    repeat (3)
    begin
      r = lfsr(r);
      slow = r[31];
      run(r[19:0], int'(r[25:20]));
    end
    step(12);
    chk("sleep", {sleep, dq_oe, dq_out}, {2'b11, word(cur)});
    $display("random burst test done");
    cmd(1);
    step(4);
    chk("disable", bmode, 1'b0);
    bc(1'b0, 1'b1, 1'b0);
    bc(1'b1, 1'b0, 1'b1);
    chk("async", {bmode, last_n}, 2'b01);
    addr = 20'h00a5c;
    gate_n = 1'b0;
    step(20);
    chk("async read", {dq_oe, dq_out}, {1'b1, word(addr)});
    gate_n = 1'b1;
    cmd(5);
    for (int i = 0; i < 6; i++)
    begin
      if (i == 4)
        cmd(3);
      r = lfsr(r);
      wr(r[19:0], r[31:16]);
      if (i == 2)
        chk("seq3", n_seq, 0);
    end
    chk("seq", {bypass, 30'(n_seq)}, {1'b1, 30'd2});
    cmd(4);
    chk("bypass off", bypass, 1'b0);
    $display("write test done");
    cmd(0);
    step(4);
    busy = 1'b1;
    step(2);
    hrst_n = 1'b0;
    step(10);
    busy = 1'b0;
    chk("pin reset", {bmode, bypass, dq_oe, done}, 4'b0000);
    hrst_n = 1'b1;
    for (k = 0; k < 1000 && done !== 1'b1; k++)
      step(1);
    chk("busy", k > 700 && k <= 800, 1'b1);
    chk("after", bmode, 1'b0);
    $display("reset pin test done");
    step(20);
    end_of_test();
  end
endmodule
